// [rtl/abc_core.sv]
// abc_core: decode and datapath for literal and, file and, bit clear
// assumes the core fetches insn before phase 0 and the file port answers
// in the read phase; other opcodes pass through untouched
//
// Operation
// - opcode high byte B5 ands the literal into the working register.
// - literal and decodes, fetches, computes, then writes working reg.
// - file and with d=0 stores working reg and file reg to working reg.
// - file and with d=1 writes the file register, working reg unchanged.
// - file and decodes, reads, computes, writes; for d=1 file_we is high in the next cycle's phase 0.
// - bit clear clears bit b of the file register, flags untouched.
`timescale 1ns/1ns
`default_nettype none
module abc_core
    import abc_pkg::*;
(
    input  wire logic [INSN_W-1:0] insn,
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              phase_en,
    input  wire logic [DATA_W-1:0] file_rdata,
    output logic [ADDR_W-1:0]      file_addr,
    output logic                   file_rd,
    output logic                   file_we,
    output logic [DATA_W-1:0]      file_wdata,
    output logic [DATA_W-1:0]      working_register,
    output logic                   zero_flag,
    output logic [1:0]             phase
);
    abc_op_type          op;
    abc_op_type          next_op;
    logic                dest_file;
    logic [2:0]          bit_sel;
    logic [DATA_W-1:0]   operand;
    logic [DATA_W-1:0]   result;
    logic [DATA_W-1:0]   next_result;

    abc_phase abc_phase_inst (
        .clock    (clock),
        .rst_n    (rst_n),
        .phase_en (phase_en),
        .phase    (phase)
    );

    always_comb begin
        next_op = ABC_OP_NONE;
        if (insn[15:8] == AND_LITERAL_CODE) begin
            next_op = ABC_OP_AND_LIT;
        end else if (insn[15:9] == AND_FILE_CODE) begin
            next_op = ABC_OP_AND_FILE;
        end else if (insn[15:11] == BIT_CLEAR_CODE) begin
            next_op = ABC_OP_BIT_CLEAR;
        end
    end

    // phase 0: decode and latch fields
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            op        <= ABC_OP_NONE;
            dest_file <= 1'h0;
            bit_sel   <= 3'h0;
            file_addr <= '0;
        end else if (phase_en && phase == PHASE_DECODE) begin
            op        <= next_op;
            dest_file <= insn[FILE_DEST_POS];
            bit_sel   <= insn[BIT_SEL_POS +: 3];
            file_addr <= insn[7:0];
        end
    end

    assign file_rd = (phase == PHASE_READ) &&
                     (op == ABC_OP_AND_FILE || op == ABC_OP_BIT_CLEAR);

    // phase 1: literal or file operand
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            operand <= '0;
        end else if (phase_en && phase == PHASE_READ) begin
            operand <= (op == ABC_OP_AND_LIT) ? insn[7:0] : file_rdata;
        end
    end

    always_comb begin
        case (op)
            ABC_OP_AND_LIT, ABC_OP_AND_FILE:
                next_result = working_register & operand;
            ABC_OP_BIT_CLEAR:
                next_result = operand & ~(8'h01 << bit_sel);
            default:
                next_result = operand;
        endcase
    end

    // phase 2: process
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result <= '0;
        end else if (phase_en && phase == PHASE_PROCESS) begin
            result <= next_result;
        end
    end

    // phase 3: write destination
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            working_register <= WORK_RESET;
        end else if (phase_en && phase == PHASE_WRITE) begin
            if (op == ABC_OP_AND_LIT ||
                (op == ABC_OP_AND_FILE && !dest_file)) begin
                working_register <= result;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            zero_flag <= ZERO_RESET;
        end else if (phase_en && phase == PHASE_WRITE &&
                     (op == ABC_OP_AND_LIT || op == ABC_OP_AND_FILE)) begin
            zero_flag <= (result == 8'h00);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            file_we    <= 1'h0;
            file_wdata <= '0;
        end else begin
            file_we <= phase_en && phase == PHASE_WRITE &&
                       ((op == ABC_OP_AND_FILE && dest_file) ||
                        op == ABC_OP_BIT_CLEAR);
            if (phase_en && phase == PHASE_WRITE) begin
                file_wdata <= result;
            end
        end
    end

    wr_when_lit_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op == ABC_OP_AND_LIT
        |=> working_register == $past(result))
        else $error("literal and did not write working register");

    idle_op_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op == ABC_OP_NONE
        |=> !file_we && $stable(working_register) && $stable(zero_flag))
        else $error("unknown opcode changed state");

    lit_operand_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_READ && op == ABC_OP_AND_LIT
        |=> operand == $past(insn[7:0]))
        else $error("literal not taken in read phase");

    lit_no_read_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase == PHASE_READ && op == ABC_OP_AND_LIT |-> !file_rd)
        else $error("literal and read the file port");

    lit_result_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_PROCESS && op == ABC_OP_AND_LIT
        |=> result == ($past(working_register) & $past(operand)))
        else $error("literal and result wrong");

    file_dest_w_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op == ABC_OP_AND_FILE &&
        !dest_file |=> !file_we)
        else $error("file write on d=0");

    file_to_w_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op == ABC_OP_AND_FILE &&
        !dest_file |=> working_register == $past(result))
        else $error("d=0 did not write working register");

    file_result_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_PROCESS && op == ABC_OP_AND_FILE
        |=> result == ($past(working_register) & $past(operand)))
        else $error("file and result wrong");

    file_dest_f_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op == ABC_OP_AND_FILE &&
        dest_file |=> file_we && $stable(working_register))
        else $error("d=1 did not write file only");

    file_wdata_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op == ABC_OP_AND_FILE &&
        dest_file |=> file_wdata == $past(result))
        else $error("d=1 write data wrong");

    one_write_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        file_we |-> $past(phase_en) && $past(phase) == PHASE_WRITE)
        else $error("file write outside write phase");

    file_read_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase == PHASE_READ && op == ABC_OP_AND_FILE |-> file_rd)
        else $error("file and did not read in read phase");

    file_operand_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_READ && op == ABC_OP_AND_FILE
        |=> operand == $past(file_rdata))
        else $error("file operand not taken in read phase");

    phase_step_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en |=> phase == $past(phase) + 2'h1)
        else $error("phase did not advance");

    latch_addr_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_DECODE |=> file_addr == $past(insn[7:0]))
        else $error("file address not latched at decode");

    bit_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        file_we && $past(op) == ABC_OP_BIT_CLEAR
        |-> file_wdata == ($past(operand) & ~(8'h01 << $past(bit_sel))))
        else $error("bit clear data wrong");

    clear_flags_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        op == ABC_OP_BIT_CLEAR && phase == PHASE_WRITE && phase_en
        |=> $stable(zero_flag))
        else $error("bit clear changed zero flag");

    clear_work_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        op == ABC_OP_BIT_CLEAR && phase == PHASE_WRITE && phase_en
        |=> $stable(working_register))
        else $error("bit clear changed working register");

    zero_set_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        phase_en && phase == PHASE_WRITE && op != ABC_OP_BIT_CLEAR &&
        op != ABC_OP_NONE |=> zero_flag == ($past(result) == 8'h00))
        else $error("zero flag wrong");
endmodule // abc_core
`default_nettype wire

// [rtl/abc_pkg.sv]
// abc_pkg: constants for the and / bit clear instruction block
// assumes a 16-bit instruction word, 8-bit data and 4 phases per cycle
package abc_pkg;
    localparam int DATA_W = 8;
    localparam int INSN_W = 16;
    localparam int ADDR_W = 8;
    localparam logic [7:0] AND_LITERAL_CODE = 8'hB5;
    localparam logic [6:0] AND_FILE_CODE = 7'h05;
    localparam logic [4:0] BIT_CLEAR_CODE = 5'h11;
    localparam int FILE_DEST_POS = 8;
    localparam int BIT_SEL_POS = 8;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic       ZERO_RESET = 1'h0;
    localparam logic [1:0] PHASE_DECODE = 2'h0;
    localparam logic [1:0] PHASE_READ = 2'h1;
    localparam logic [1:0] PHASE_PROCESS = 2'h2;
    localparam logic [1:0] PHASE_WRITE = 2'h3;
    typedef enum logic [1:0] {
        ABC_OP_NONE      = 2'b00,
        ABC_OP_AND_LIT   = 2'b01,
        ABC_OP_AND_FILE  = 2'b10,
        ABC_OP_BIT_CLEAR = 2'b11
    } abc_op_type;
endpackage : abc_pkg

// [rtl/abc_phase.sv]
// abc_phase: four-phase sequencer for one instruction cycle
// assumes phase_en pulses once per phase from the core clock divider
`timescale 1ns/1ns
`default_nettype none
module abc_phase
    import abc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       phase_en,
    output logic [1:0]      phase
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase <= PHASE_DECODE;
        end else if (phase_en) begin
            phase <= phase + 2'h1;
        end
    end
endmodule // abc_phase
`default_nettype wire

// [tb/abc_core_bench.sv]
// abc_core_bench: self-checking bench for the and / bit clear block
// assumes phase_en held high, so every clock advances one phase
`timescale 1ns/1ns
`default_nettype none
module abc_core_bench
    import abc_pkg::*;
;
    logic              clock;
    logic              rst_n;
    logic              phase_en;
    logic [INSN_W-1:0] insn;
    logic [DATA_W-1:0] file_rdata;
    logic [ADDR_W-1:0] file_addr;
    logic              file_rd;
    logic              file_we;
    logic [DATA_W-1:0] file_wdata;
    logic [DATA_W-1:0] working_register;
    logic              zero_flag;
    logic [1:0]        phase;
    logic              exp_z;
    int                n_errors;
    int                n_checks;
    int                cycles;

    abc_core abc_core_inst (.insn(insn), .clock(clock), .rst_n(rst_n),
        .phase_en(phase_en), .file_rdata(file_rdata), .file_addr(file_addr),
        .file_rd(file_rd), .file_we(file_we), .file_wdata(file_wdata),
        .working_register(working_register), .zero_flag(zero_flag),
        .phase(phase));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one instruction: launched at the phase 3 edge, judged after four more
    task automatic run(input logic [15:0] v, input logic [7:0] rd,
                       input logic rd_exp, input logic we_exp,
                       input logic [7:0] wd_exp);
        int k;
        k = 0;
        @(posedge clock);
        #1;
        chk("file write end", 8'h00, {7'h00, file_we});
        while (phase !== PHASE_WRITE && k < 8) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk("phase", {6'h00, PHASE_WRITE}, {6'h00, phase});
        @(posedge clock);
        insn <= v;
        file_rdata <= rd;
        @(posedge clock);
        #1;
        chk("file read", {7'h00, rd_exp}, {7'h00, file_rd});
        repeat (3) @(posedge clock);
        insn <= 16'h0000;
        file_rdata <= ~rd;
        #1;
        chk("file write", {7'h00, we_exp}, {7'h00, file_we});
        if (we_exp) begin
            chk("write data", wd_exp, file_wdata);
            chk("file addr", v[7:0], file_addr);
        end
        chk("working reg", 8'h00, working_register);
        chk("zero flag", {7'h00, exp_z}, {7'h00, zero_flag});
    endtask

    task automatic t_unknown();
        run(16'hB412, 8'h00, 1'h0, 1'h0, 8'h00);
        run(16'h0E12, 8'hFF, 1'h0, 1'h0, 8'h00);
        run(16'h8012, 8'h00, 1'h0, 1'h0, 8'h00);
    endtask

    task automatic t_bit_clear();
        for (int b = 0; b < 8; b++) begin
            run({BIT_CLEAR_CODE, b[2:0], 8'h3C}, 8'hFF, 1'h1, 1'h1,
                8'hFF & ~(8'h01 << b));
        end
        run({BIT_CLEAR_CODE, 3'h7, 8'h20}, 8'hC7, 1'h1, 1'h1,
            8'h47);
    endtask

    task automatic t_and_lit();
        exp_z = 1'h1;
        run({AND_LITERAL_CODE, 8'h5F}, 8'hA3, 1'h0, 1'h0,
            8'h00);
    endtask

    task automatic t_and_file();
        run({AND_FILE_CODE, 1'h0, 8'h41}, 8'hC2, 1'h1, 1'h0,
            8'h00);
        run({AND_FILE_CODE, 1'h1, 8'h42}, 8'hC2, 1'h1, 1'h1,
            8'h00);
    endtask

    initial begin
        rst_n = 1'h0;
        phase_en = 1'h0;
        insn = 16'h0000;
        file_rdata = 8'h00;
        exp_z = 1'h0;
        n_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clock);
        rst_n <= 1'h1;
        phase_en <= 1'h1;
        @(posedge clock);
        #1;
        chk("reset working reg", WORK_RESET, working_register);
        chk("reset zero flag", {7'h00, ZERO_RESET}, {7'h00, zero_flag});
        t_unknown();
        t_bit_clear();
        t_and_lit();
        t_and_file();
        t_bit_clear();
        end_sim();
    end
endmodule // abc_core_bench
`default_nettype wire
